// *** src/vrf_pkg.sv ***
package vrf_pkg;
	localparam int POS_W = 13;
	localparam int SEL_W = 18;
	localparam int SEL_HI_W = 5;
	localparam int NUM_GROUPS = 4;
	localparam int NUM_VOUT = 24;
	localparam int GRP_A = 0;

	// Line alternation modes.
	localparam logic [1:0] ALT_SINGLE = 2'h0;
	localparam logic [1:0] ALT_TWO_LINE = 2'h1;
	localparam logic [1:0] ALT_THREE_LINE = 2'h2;
	localparam logic [1:0] ALT_FOUR_LINE = 2'h3;

	// Groups B, C and D walk a five-line pattern in three-line mode.
	localparam logic [2:0] BCD_WRAP_THREE_LINE = 3'h4;
	localparam logic [2:0] BCD_WRAP_DEFAULT = 3'h1;

	localparam logic [POS_W-1:0] POS_RESET = 13'h0000;
	localparam logic [POS_W-1:0] REP_FIRST = 13'h0001;
	localparam logic [2:0] LINE_IDX_RESET = 3'h0;
	localparam logic [NUM_VOUT-1:0] VOUT_RESET = 24'h000000;
	localparam logic [SEL_W-1:0] SEL_RESET = 18'h00000;

	typedef enum logic {
		VRF_IDLE,
		VRF_RUN
	} vrf_seq_state_t;
endpackage : vrf_pkg

// *** src/vrf_hold_window.sv ***
`timescale 1ns/1ps
module vrf_hold_window (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic enable_in,
	input wire logic line_start_in,
	input wire logic [vrf_pkg::POS_W-1:0] pixel_pos_in,
	input wire logic [vrf_pkg::POS_W-1:0] hold_pos_in,
	input wire logic [vrf_pkg::POS_W-1:0] release_pos_in,
	output logic held_out
);
	typedef struct packed {
		logic held;
	} vrf_hold_state_t;

	vrf_hold_state_t st_reg;
	vrf_hold_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (!enable_in || line_start_in)
			st_next.held = 1'b0;
		else if (pixel_pos_in == release_pos_in)
			st_next.held = 1'b0;
		else if (pixel_pos_in == hold_pos_in)
			st_next.held = 1'b1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign held_out = st_reg.held;

	hold_start_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		enable_in && !line_start_in && pixel_pos_in == hold_pos_in
			&& pixel_pos_in != release_pos_in |=> held_out)
		else $error("hold window did not open at hold position");

	hold_release_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		held_out && pixel_pos_in == release_pos_in |=> !held_out)
		else $error("hold window did not close at release position");
endmodule : vrf_hold_window

// *** src/vrf_group_seq.sv ***
`timescale 1ns/1ps
module vrf_group_seq (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic line_start_in,
	input wire logic [vrf_pkg::POS_W-1:0] pixel_pos_in,
	input wire logic [vrf_pkg::POS_W-1:0] start_pos_in,
	input wire logic [vrf_pkg::POS_W-1:0] length_in,
	input wire logic [vrf_pkg::POS_W-1:0] final_length_in,
	input wire logic final_length_en_in,
	input wire logic [vrf_pkg::POS_W-1:0] reps_in,
	input wire logic [vrf_pkg::POS_W-1:0] extra_pos_in,
	input wire logic extra_en_in,
	output logic active_out,
	output logic final_rep_out,
	output logic extra_toggle_out
);
	typedef struct packed {
		vrf_pkg::vrf_seq_state_t state;
		logic [vrf_pkg::POS_W-1:0] pos;
		logic [vrf_pkg::POS_W-1:0] rep;
		logic active;
		logic final_rep;
		logic extra;
	} vrf_group_state_t;

	vrf_group_state_t st_reg;
	vrf_group_state_t st_next;
	logic last;
	logic end_of_rep;
	logic [vrf_pkg::POS_W-1:0] cur_len;

	always_comb
	begin
		last = (st_reg.rep == reps_in);
		cur_len = (last && final_length_en_in) ? final_length_in : length_in;
		// A zero length is treated as one so a bad setting cannot stall the group.
		end_of_rep = ({1'b0, st_reg.pos} + 14'h0001) >= {1'b0, cur_len};
		st_next = st_reg;
		st_next.extra = 1'b0;
		unique case (st_reg.state)
			vrf_pkg::VRF_IDLE:
			begin
				if (!line_start_in && pixel_pos_in == start_pos_in && reps_in != '0)
				begin
					st_next.state = vrf_pkg::VRF_RUN;
					st_next.pos = vrf_pkg::POS_RESET;
					st_next.rep = vrf_pkg::REP_FIRST;
				end
			end
			vrf_pkg::VRF_RUN:
			begin
				// One toggle point shared by every output of the group.
				st_next.extra = extra_en_in && last && st_reg.pos == extra_pos_in;
				if (line_start_in)
					st_next.state = vrf_pkg::VRF_IDLE;
				else if (end_of_rep)
				begin
					if (last)
						st_next.state = vrf_pkg::VRF_IDLE;
					else
					begin
						st_next.rep = st_reg.rep + vrf_pkg::REP_FIRST;
						st_next.pos = vrf_pkg::POS_RESET;
					end
				end
				else
					st_next.pos = st_reg.pos + vrf_pkg::REP_FIRST;
			end
		endcase
		st_next.active = (st_next.state == vrf_pkg::VRF_RUN);
		st_next.final_rep = st_next.active && (st_next.rep == reps_in);
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign active_out = st_reg.active;
	assign final_rep_out = st_reg.final_rep;
	assign extra_toggle_out = st_reg.extra;

	final_len_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.state == vrf_pkg::VRF_RUN && last && final_length_en_in
			&& final_length_in != '0 && st_reg.pos == final_length_in - 13'h0001
			|=> st_reg.state == vrf_pkg::VRF_IDLE)
		else $error("final repetition did not end at final length");

	plain_len_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.state == vrf_pkg::VRF_RUN && !last && !line_start_in && length_in != '0
			&& st_reg.pos == length_in - 13'h0001
			|=> st_reg.pos == '0 && st_reg.rep == $past(st_reg.rep) + 13'h0001)
		else $error("normal repetition did not wrap at pattern length");

	extra_gate_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		extra_toggle_out |-> $past(extra_en_in) && $past(last))
		else $error("extra toggle outside enabled final repetition");

	seq_run_c: cover property (
		@(posedge clk_in) disable iff (!rst_n_in)
		final_rep_out ##1 !active_out);
endmodule : vrf_group_seq

// *** src/vseq_repeat_freeze_control.sv ***
`timescale 1ns/1ps
// Function
// - Group A repetitions for third line
// - Group A repetitions for fourth line
// - Groups B-D repetitions for odd lines
// - Groups B-D repetitions for even lines
// - Four hold positions stop vertical outputs
// - Four paired release positions restart outputs
// - Special mode: hold regs give select low bits
// - Special mode: release regs give select high bits
// - Enabled final repetition uses separate length
// - Enabled optional fifth toggle per group
// - Fifth toggle shared by group outputs
// - Final-length enable: one bit per group
// - Fifth-toggle enable: one bit per group
// - Four-line: A cycles four, others alternate
module vseq_repeat_freeze_control (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic seq_start_in,
	input wire logic line_start_in,
	input wire logic [vrf_pkg::POS_W-1:0] pixel_pos_in,
	input wire logic [vrf_pkg::NUM_VOUT-1:0] v_pattern_in,
	input wire logic [2*vrf_pkg::NUM_VOUT-1:0] group_map_in,
	input wire logic [1:0] alternation_mode_in,
	input wire logic [3:0] vertical_hold_mask_enable_in,
	input wire logic special_alternation_enable_in,
	input wire logic [3:0] final_rep_length_enable_in,
	input wire logic [3:0] extra_toggle_enable_in,
	input wire logic [3:0][vrf_pkg::POS_W-1:0] group_pattern_start_in,
	input wire logic [3:0][vrf_pkg::POS_W-1:0] group_pattern_length_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_a_reps_line1_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_a_reps_line2_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_a_reps_line3_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_a_reps_line4_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_b_reps_odd_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_c_reps_odd_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_d_reps_odd_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_b_reps_even_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_c_reps_even_in,
	input wire logic [vrf_pkg::POS_W-1:0] group_d_reps_even_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_hold_point_1_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_hold_point_2_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_hold_point_3_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_hold_point_4_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_release_point_1_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_release_point_2_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_release_point_3_in,
	input wire logic [vrf_pkg::POS_W-1:0] v_release_point_4_in,
	input wire logic [vrf_pkg::POS_W-1:0] final_rep_length_a_in,
	input wire logic [vrf_pkg::POS_W-1:0] final_rep_length_b_in,
	input wire logic [vrf_pkg::POS_W-1:0] final_rep_length_c_in,
	input wire logic [vrf_pkg::POS_W-1:0] final_rep_length_d_in,
	input wire logic [vrf_pkg::POS_W-1:0] extra_toggle_pos_a_in,
	input wire logic [vrf_pkg::POS_W-1:0] extra_toggle_pos_b_in,
	input wire logic [vrf_pkg::POS_W-1:0] extra_toggle_pos_c_in,
	input wire logic [vrf_pkg::POS_W-1:0] extra_toggle_pos_d_in,
	output logic [vrf_pkg::NUM_VOUT-1:0] vertical_output_out,
	output logic vertical_held_out,
	output logic [3:0] group_active_out,
	output logic [3:0] group_final_rep_out,
	output logic [vrf_pkg::SEL_W-1:0] even_segment_select_0_out,
	output logic [vrf_pkg::SEL_W-1:0] even_segment_select_1_out,
	output logic [vrf_pkg::SEL_W-1:0] odd_segment_select_0_out,
	output logic [vrf_pkg::SEL_W-1:0] odd_segment_select_1_out
);
	typedef struct packed {
		logic [2:0] a_idx;
		logic [2:0] bcd_idx;
		logic first;
		logic [vrf_pkg::NUM_VOUT-1:0] tog;
		logic [vrf_pkg::NUM_VOUT-1:0] vout;
		logic held;
		logic [3:0][vrf_pkg::SEL_W-1:0] seg;
	} vrf_top_state_t;

	vrf_top_state_t st_reg;
	vrf_top_state_t st_next;
	logic [3:0][vrf_pkg::POS_W-1:0] reps_sel;
	logic [3:0][vrf_pkg::POS_W-1:0] final_len;
	logic [3:0][vrf_pkg::POS_W-1:0] extra_pos;
	logic [3:0][vrf_pkg::POS_W-1:0] hold_pos;
	logic [3:0][vrf_pkg::POS_W-1:0] release_pos;
	logic [3:0] window_held;
	logic [3:0] group_active;
	logic [3:0] group_final;
	logic [3:0] extra_pulse;
	logic [vrf_pkg::NUM_VOUT-1:0] tog_flip;
	logic bcd_even;
	logic [2:0] a_wrap;
	logic [2:0] bcd_wrap;

	assign final_len = {final_rep_length_d_in, final_rep_length_c_in,
		final_rep_length_b_in, final_rep_length_a_in};
	assign extra_pos = {extra_toggle_pos_d_in, extra_toggle_pos_c_in,
		extra_toggle_pos_b_in, extra_toggle_pos_a_in};
	assign hold_pos = {v_hold_point_4_in, v_hold_point_3_in,
		v_hold_point_2_in, v_hold_point_1_in};
	assign release_pos = {v_release_point_4_in, v_release_point_3_in,
		v_release_point_2_in, v_release_point_1_in};

	// Group A walks one count per line of the alternation cycle; B to D use parity, or a five-line cycle in three-line mode.
	always_comb
	begin
		a_wrap = {1'b0, alternation_mode_in};
		bcd_wrap = (alternation_mode_in == vrf_pkg::ALT_THREE_LINE) ?
			vrf_pkg::BCD_WRAP_THREE_LINE : vrf_pkg::BCD_WRAP_DEFAULT;
		bcd_even = (st_reg.bcd_idx == vrf_pkg::LINE_IDX_RESET);
		unique case (st_reg.a_idx)
			3'h0: reps_sel[vrf_pkg::GRP_A] = group_a_reps_line1_in;
			3'h1: reps_sel[vrf_pkg::GRP_A] = group_a_reps_line2_in;
			3'h2: reps_sel[vrf_pkg::GRP_A] = group_a_reps_line3_in;
			3'h3: reps_sel[vrf_pkg::GRP_A] = group_a_reps_line4_in;
			default: reps_sel[vrf_pkg::GRP_A] = group_a_reps_line1_in;
		endcase
		reps_sel[1] = bcd_even ? group_b_reps_even_in : group_b_reps_odd_in;
		reps_sel[2] = bcd_even ? group_c_reps_even_in : group_c_reps_odd_in;
		reps_sel[3] = bcd_even ? group_d_reps_even_in : group_d_reps_odd_in;
	end

	genvar g;
	generate
		for (g = 0; g < vrf_pkg::NUM_GROUPS; g++)
		begin : gen_group
			vrf_group_seq u_seq (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.line_start_in(line_start_in),
				.pixel_pos_in(pixel_pos_in),
				.start_pos_in(group_pattern_start_in[g]),
				.length_in(group_pattern_length_in[g]),
				.final_length_in(final_len[g]),
				.final_length_en_in(final_rep_length_enable_in[g]),
				.reps_in(reps_sel[g]),
				.extra_pos_in(extra_pos[g]),
				.extra_en_in(extra_toggle_enable_in[g]),
				.active_out(group_active[g]),
				.final_rep_out(group_final[g]),
				.extra_toggle_out(extra_pulse[g])
			);
			// In special mode these registers carry segment selects, so no hold applies.
			vrf_hold_window u_hold (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.enable_in(vertical_hold_mask_enable_in[g] && !special_alternation_enable_in),
				.line_start_in(line_start_in),
				.pixel_pos_in(pixel_pos_in),
				.hold_pos_in(hold_pos[g]),
				.release_pos_in(release_pos[g]),
				.held_out(window_held[g])
			);
		end
	endgenerate

	genvar v;
	generate
		for (v = 0; v < vrf_pkg::NUM_VOUT; v++)
		begin : gen_vout
			assign tog_flip[v] = extra_pulse[group_map_in[2*v +: 2]];
		end
	endgenerate

	always_comb
	begin
		st_next = st_reg;
		if (seq_start_in)
			st_next.first = 1'b1;
		else if (line_start_in)
		begin
			st_next.first = 1'b0;
			if (st_reg.first)
			begin
				st_next.a_idx = vrf_pkg::LINE_IDX_RESET;
				st_next.bcd_idx = vrf_pkg::LINE_IDX_RESET;
			end
			else
			begin
				st_next.a_idx = (st_reg.a_idx >= a_wrap) ?
					vrf_pkg::LINE_IDX_RESET : st_reg.a_idx + 3'h1;
				st_next.bcd_idx = (st_reg.bcd_idx >= bcd_wrap) ?
					vrf_pkg::LINE_IDX_RESET : st_reg.bcd_idx + 3'h1;
			end
		end
		st_next.tog = line_start_in ? vrf_pkg::VOUT_RESET : (st_reg.tog ^ tog_flip);
		st_next.held = |window_held;
		// The output keeps the level it had when the window opened.
		st_next.vout = (|window_held) ? st_reg.vout : (v_pattern_in ^ st_reg.tog);
		// Outside special mode the words read as zero, so a stale select cannot steer a merge.
		for (int k = 0; k < 4; k++)
		begin
			st_next.seg[k] = special_alternation_enable_in ?
				{release_pos[k][vrf_pkg::SEL_HI_W-1:0], hold_pos[k]} :
				vrf_pkg::SEL_RESET;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_reg <= '0;
			st_reg.first <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign vertical_output_out = st_reg.vout;
	assign vertical_held_out = st_reg.held;
	assign group_active_out = group_active;
	assign group_final_rep_out = group_final;
	assign even_segment_select_0_out = st_reg.seg[0];
	assign even_segment_select_1_out = st_reg.seg[1];
	assign odd_segment_select_0_out = st_reg.seg[2];
	assign odd_segment_select_1_out = st_reg.seg[3];

	seg_low_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		special_alternation_enable_in |=>
			odd_segment_select_1_out[12:0] == $past(v_hold_point_4_in)
			&& even_segment_select_0_out[12:0] == $past(v_hold_point_1_in))
		else $error("segment select low bits not taken from hold points");

	seg_high_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		special_alternation_enable_in |=>
			even_segment_select_1_out[17:13] == $past(v_release_point_2_in[4:0])
			&& odd_segment_select_0_out[17:13] == $past(v_release_point_3_in[4:0]))
		else $error("segment select high bits not taken from release points");

	special_nohold_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		special_alternation_enable_in [*2] |=> !vertical_held_out)
		else $error("outputs held while special alternation is on");

	hold_level_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		vertical_held_out |-> $stable(vertical_output_out))
		else $error("vertical outputs changed inside hold window");

	rep_line3_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		st_reg.a_idx == 3'h2 |-> reps_sel[0] == group_a_reps_line3_in)
		else $error("third line count not selected for group A");

	a_cycle_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		alternation_mode_in == vrf_pkg::ALT_FOUR_LINE && line_start_in && !seq_start_in
			&& !st_reg.first && st_reg.a_idx == 3'h2
			|=> st_reg.a_idx == 3'h3 && reps_sel[0] == group_a_reps_line4_in)
		else $error("group A did not step to fourth line count");

	bcd_odd_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		alternation_mode_in == vrf_pkg::ALT_FOUR_LINE && line_start_in && !seq_start_in
			&& !st_reg.first && bcd_even |=> reps_sel[1] == group_b_reps_odd_in)
		else $error("group B odd count not used on odd line");

	bcd_even_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		line_start_in && st_reg.first && !seq_start_in
			|=> reps_sel[3] == group_d_reps_even_in)
		else $error("group D even count not used on first line");

	shared_tog_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		extra_pulse[group_map_in[1:0]] && !line_start_in |=> st_reg.tog[0] != $past(st_reg.tog[0]))
		else $error("shared extra toggle missed an output of its group");

	seg_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!special_alternation_enable_in |=>
			even_segment_select_0_out == '0 && odd_segment_select_1_out == '0)
		else $error("segment selects not cleared outside special alternation");

	tog_clear_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		line_start_in |=> st_reg.tog == vrf_pkg::VOUT_RESET)
		else $error("extra toggle state survived a line start");

	a_wrap_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		alternation_mode_in == vrf_pkg::ALT_FOUR_LINE && line_start_in && !seq_start_in
			&& !st_reg.first && st_reg.a_idx == 3'h3
			|=> st_reg.a_idx == vrf_pkg::LINE_IDX_RESET
			&& reps_sel[0] == group_a_reps_line1_in)
		else $error("group A did not return to first line count");

	bcd_wrap_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		alternation_mode_in == vrf_pkg::ALT_THREE_LINE && line_start_in && !seq_start_in
			&& !st_reg.first && st_reg.bcd_idx == vrf_pkg::BCD_WRAP_THREE_LINE
			|=> bcd_even && reps_sel[2] == group_c_reps_even_in)
		else $error("groups B to D did not return to even count");

	special_c: cover property (
		@(posedge clk_in) disable iff (!rst_n_in)
		special_alternation_enable_in ##1 even_segment_select_0_out != '0);

	hold_c: cover property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!vertical_held_out ##1 vertical_held_out [*3] ##1 !vertical_held_out);

	four_line_c: cover property (
		@(posedge clk_in) disable iff (!rst_n_in)
		alternation_mode_in == vrf_pkg::ALT_FOUR_LINE && st_reg.a_idx == 3'h3);

	extra_c: cover property (
		@(posedge clk_in) disable iff (!rst_n_in)
		|extra_pulse);
endmodule : vseq_repeat_freeze_control

// *** tb/vrf_ccd_model.sv ***
`timescale 1ns/1ps
module vrf_ccd_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [vrf_pkg::NUM_VOUT-1:0] vertical_output_in,
	input wire logic held_in,
	output int frozen_changes_out
);
	logic [vrf_pkg::NUM_VOUT-1:0] last_level;
	logic held_prev;

	// A sensor gate that moves while the shift is frozen smears charge, so any change is counted.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			frozen_changes_out <= 0;
			held_prev <= 1'b0;
			last_level <= vrf_pkg::VOUT_RESET;
		end
		else
		begin
			if (held_prev && held_in && vertical_output_in !== last_level)
			begin
				frozen_changes_out <= frozen_changes_out + 1;
			end
			held_prev <= held_in;
			last_level <= vertical_output_in;
		end
	end
endmodule : vrf_ccd_model

// *** tb/vseq_repeat_freeze_control_test.sv ***
`timescale 1ns/1ps
module vseq_repeat_freeze_control_test;
	localparam int LINE_LEN = 200;
	localparam int MAX_CYCLES = 8000;
	logic clk_in;
	logic rst_n_in;
	logic seq_start_in;
	logic line_start_in;
	logic [12:0] pixel_pos_in;
	logic [23:0] v_pattern_in;
	logic [47:0] group_map_in;
	logic [1:0] mode;
	logic special;
	logic [3:0] mask_en;
	logic [3:0] final_en;
	logic [3:0] extra_en;
	logic [3:0][12:0] start_pos;
	logic [3:0][12:0] pat_len;
	logic [12:0] a_reps [4];
	logic [12:0] odd_reps [4];
	logic [12:0] even_reps [4];
	logic [12:0] hold_pt [4];
	logic [12:0] rel_pt [4];
	logic [12:0] final_len [4];
	logic [12:0] extra_pos [4];
	logic [23:0] vout;
	logic held;
	logic [3:0] active;
	logic [3:0] final_rep;
	logic [17:0] sel_seen [4];
	logic [31:0] rng;
	int frozen_changes;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	vseq_repeat_freeze_control dut_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .seq_start_in(seq_start_in),
		.line_start_in(line_start_in), .pixel_pos_in(pixel_pos_in),
		.v_pattern_in(v_pattern_in), .group_map_in(group_map_in),
		.alternation_mode_in(mode), .vertical_hold_mask_enable_in(mask_en),
		.special_alternation_enable_in(special), .final_rep_length_enable_in(final_en),
		.extra_toggle_enable_in(extra_en), .group_pattern_start_in(start_pos),
		.group_pattern_length_in(pat_len),
		.group_a_reps_line1_in(a_reps[0]), .group_a_reps_line2_in(a_reps[1]),
		.group_a_reps_line3_in(a_reps[2]), .group_a_reps_line4_in(a_reps[3]),
		.group_b_reps_odd_in(odd_reps[1]), .group_c_reps_odd_in(odd_reps[2]),
		.group_d_reps_odd_in(odd_reps[3]), .group_b_reps_even_in(even_reps[1]),
		.group_c_reps_even_in(even_reps[2]), .group_d_reps_even_in(even_reps[3]),
		.v_hold_point_1_in(hold_pt[0]), .v_hold_point_2_in(hold_pt[1]),
		.v_hold_point_3_in(hold_pt[2]), .v_hold_point_4_in(hold_pt[3]),
		.v_release_point_1_in(rel_pt[0]), .v_release_point_2_in(rel_pt[1]),
		.v_release_point_3_in(rel_pt[2]), .v_release_point_4_in(rel_pt[3]),
		.final_rep_length_a_in(final_len[0]), .final_rep_length_b_in(final_len[1]),
		.final_rep_length_c_in(final_len[2]), .final_rep_length_d_in(final_len[3]),
		.extra_toggle_pos_a_in(extra_pos[0]), .extra_toggle_pos_b_in(extra_pos[1]),
		.extra_toggle_pos_c_in(extra_pos[2]), .extra_toggle_pos_d_in(extra_pos[3]),
		.vertical_output_out(vout), .vertical_held_out(held),
		.group_active_out(active), .group_final_rep_out(final_rep),
		.even_segment_select_0_out(sel_seen[0]), .even_segment_select_1_out(sel_seen[1]),
		.odd_segment_select_0_out(sel_seen[2]), .odd_segment_select_1_out(sel_seen[3])
	);

	vrf_ccd_model ccd_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .vertical_output_in(vout),
		.held_in(held), .frozen_changes_out(frozen_changes)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles >= MAX_CYCLES)
		begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : next_rand

	function automatic logic [12:0] rnd(input int lo, input int hi);
		rng = next_rand(rng);
		return 13'(lo + (rng % (hi - lo + 1)));
	endfunction : rnd

	function automatic int fl(input int g);
		return final_en[g] ? int'(final_len[g]) : int'(pat_len[g]);
	endfunction : fl

	// Lines count from the first after the sequence start, which is even.
	function automatic int exp_reps(input int g, input int i);
		int n;
		// Single-line mode keeps group A on its first count.
		n = (mode == 2'h3) ? 4 : ((mode == 2'h2) ? 3 : ((mode == 2'h1) ? 2 : 1));
		if (g == 0)
			return int'(a_reps[i % n]);
		return ((mode == 2'h2) ? (i % 5 == 0) : (i % 2 == 0)) ? even_reps[g] : odd_reps[g];
	endfunction : exp_reps

	function automatic logic [23:0] extra_mask();
		logic [23:0] m;
		m = 24'h000000;
		for (int i = 0; i < 24; i++)
			m[i] = extra_en[group_map_in[2*i +: 2]];
		return m;
	endfunction : extra_mask

	task automatic setup_line();
		mask_en = 4'(rnd(0, 15));
		special = (rnd(0, 3) == 0);
		final_en = 4'(rnd(0, 15));
		extra_en = (rnd(0, 1) == 0) ? 4'h0 : 4'(rnd(0, 15));
		rng = next_rand(rng);
		group_map_in = {rng, rng[31:16]};
		for (int k = 0; k < 4; k++)
		begin
			start_pos[k] = rnd(1, 20);
			pat_len[k] = rnd(1, 8);
			final_len[k] = (rnd(0, 1) == 0) ? pat_len[k] : rnd(1, 8);
			extra_pos[k] = rnd(0, fl(k) - 1);
			a_reps[k] = rnd(1, 4);
			odd_reps[k] = rnd(1, 4);
			even_reps[k] = rnd(1, 4);
			hold_pt[k] = rnd(30, 100);
			rel_pt[k] = (rnd(0, 4) == 0) ? hold_pt[k] : rnd(int'(hold_pt[k]), 190);
		end
	endtask : setup_line

	task automatic check_idle();
		check("idle vout", 32'(vout), 32'h0);
		check("idle held", 32'(held), 32'h0);
		check("idle groups", 32'({active, final_rep}), 32'h0);
		check("idle select", 32'(sel_seen[0] | sel_seen[3]), 32'h0);
	endtask : check_idle

	task automatic run_line(input int idx);
		int act [4];
		int fin [4];
		int exp_act;
		logic [17:0] sel_exp;
		logic [3:0] held_m;
		logic [3:0] held_was;
		logic [23:0] vpat_prev;
		held_m = 4'h0;
		held_was = 4'h0;
		vpat_prev = 24'h000000;
		act = '{default: 0};
		fin = '{default: 0};
		for (int p = 0; p <= LINE_LEN; p++)
		begin
			@(negedge clk_in);
			if (p > 0)
			begin
				// The top flag is registered once more behind the window, so it lags one pixel.
				check("held", 32'(held), 32'(|held_was));
				for (int k = 0; k < 4; k++)
				begin
					sel_exp = special ? {rel_pt[k][4:0], hold_pt[k]} : 18'h00000;
					check("select", 32'(sel_seen[k]), 32'(sel_exp));
					act[k] += int'(active[k] === 1'b1);
					fin[k] += int'(final_rep[k] === 1'b1);
				end
				// Held windows with their edges, and the cycles after a line start, are left to the frozen count.
				if (p > 3 && extra_en == 4'h0 && (held_m | held_was) == 4'h0)
					check("vout", 32'(vout), 32'(vpat_prev));
			end
			if (p < LINE_LEN)
			begin
				seq_start_in = 1'b0;
				line_start_in = (p == 0);
				pixel_pos_in = 13'(p);
				rng = next_rand(rng);
				v_pattern_in = rng[23:0];
				vpat_prev = v_pattern_in;
				held_was = held_m;
				for (int k = 0; k < 4; k++)
					held_m[k] = p != 0 && mask_en[k] && !special && pixel_pos_in != rel_pt[k]
						&& (held_m[k] || pixel_pos_in == hold_pt[k]);
			end
		end
		check("toggle", 32'(vout ^ vpat_prev), 32'(extra_mask()));
		for (int g = 0; g < 4; g++)
		begin
			check("final", 32'(fin[g]), 32'(fl(g)));
			exp_act = (exp_reps(g, idx) - 1) * int'(pat_len[g]) + fl(g);
			check("active", 32'(act[g]), 32'(exp_act));
		end
	endtask : run_line

	initial
	begin
		rng = 32'h00014ab3;
		rst_n_in = 1'b0;
		seq_start_in = 1'b0;
		line_start_in = 1'b0;
		pixel_pos_in = 13'h0000;
		v_pattern_in = 24'h000000;
		mode = 2'h0;
		setup_line();
		repeat (20) @(posedge clk_in);
		@(negedge clk_in);
		check_idle();
		rst_n_in = 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			mode = 2'(m);
			for (int i = 0; i < 6; i++)
			begin
				setup_line();
				seq_start_in = (i == 0);
				run_line(i);
			end
		end
		check("frozen", 32'(frozen_changes), 32'h0);
		rst_n_in = 1'b0;
		@(negedge clk_in);
		check_idle();
		rst_n_in = 1'b1;
		setup_line();
		run_line(0);
		check("frozen after reset", 32'(frozen_changes), 32'h0);
		give_verdict();
	end
endmodule : vseq_repeat_freeze_control_test
